// ===== src/psram_cfg_pkg.sv
package psram_cfg_pkg;
	localparam int          WORD_W              = 16;
	localparam int          HI_W                = 7;
	localparam int          CNT_W               = 20;
	localparam int          MODE_BIT            = 15;
	localparam int          FIXED_BIT           = 14;
	localparam int          LAT_LSB             = 11;
	localparam int          WAIT_POL_BIT        = 10;
	localparam int          WAIT_CFG_BIT        = 8;
	localparam int          BUS_LOST_BIT        = 4;
	localparam int          DEEP_POWER_DOWN_BIT = 4;
	localparam int          REFRESH_SEL_LSB     = 0;
	localparam int          SEL_LSB             = 2;
	localparam logic [15:0] BUS_CONFIG_RESET     = 16'h9D1F;
	localparam logic [15:0] REFRESH_CONFIG_RESET = 16'h0010;
	localparam logic [15:0] REFRESH_USED_MASK    = 16'h0017;
	localparam logic [1:0]  SEL_REFRESH = 2'h0;
	localparam logic [1:0]  SEL_IDENT   = 2'h1;
	localparam logic [1:0]  SEL_BUS     = 2'h2;
	localparam logic [15:0] KEY_REFRESH = 16'h0000;
	localparam logic [15:0] KEY_BUS     = 16'h0001;
	localparam logic [15:0] KEY_IDENT   = 16'h0002;
	localparam logic        IDENT_ROW_256 = 1'h1;
	localparam logic [2:0]  IDENT_DENSITY = 3'h3;
	localparam int          CLOCK_MHZ        = 250;
	localparam int          WAKE_LOW_US      = 10;
	localparam int          INIT_US          = 150;
	localparam int          WAKE_LOW_CYCLES  = WAKE_LOW_US * CLOCK_MHZ;
	localparam int          INIT_CYCLES      = INIT_US * CLOCK_MHZ;
	localparam int          COLLISION_WINDOW = 4;

	typedef enum logic [4:0] {
		OP_CFG_WRITE = 5'h01,
		OP_CFG_READ  = 5'h02,
		OP_READ      = 5'h04,
		OP_WRITE     = 5'h08,
		OP_WAKE      = 5'h10
	} op_t;

	typedef struct packed {
		logic        none;
		logic [22:0] first;
		logic [22:0] last;
	} refresh_window_t;

	function automatic logic [3:0] latency_clocks(input logic [2:0] code, input logic fixed, input logic collision);
		logic [3:0] n;
		n = 4'h8;
		case (code)
			3'h2: n = 4'h2;
			3'h3: n = 4'h3;
			3'h4: n = 4'h4;
			3'h5: n = fixed ? 4'h5 : 4'h8;
			3'h6: n = fixed ? 4'h6 : 4'h8;
			default: n = 4'h8;
		endcase
		if (!fixed && collision && n != 4'h8) begin
			n = 4'(n << 1);
		end
		return n;
	endfunction

	function automatic refresh_window_t refresh_window(input logic [2:0] code);
		refresh_window_t w;
		w.none  = 1'h0;
		w.first = 23'h000000;
		w.last  = 23'h7FFFFF;
		case (code)
			3'h1: w.last = 23'h3FFFFF;
			3'h2: w.last = 23'h1FFFFF;
			3'h3: w.last = 23'h0FFFFF;
			3'h4: w.none = 1'h1;
			3'h5: w.first = 23'h400000;
			3'h6: w.first = 23'h600000;
			3'h7: w.first = 23'h700000;
			default: w.last = 23'h7FFFFF;
		endcase
		return w;
	endfunction
endpackage

// ===== src/psram_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface psram_link_if;
	logic        ce_n;
	logic        adv_n;
	logic        we_n;
	logic        config_register_enable;
	logic [6:0]  addr_hi;
	logic [15:0] adq_h;
	logic        adq_h_oe;
	logic [15:0] adq_d;
	logic        adq_d_oe;
	logic        wait_out;
	logic        wait_oe;

	modport device_end (
		input  ce_n, adv_n, we_n, config_register_enable, addr_hi, adq_h, adq_h_oe,
		output adq_d, adq_d_oe, wait_out, wait_oe
	);
	modport host_end (
		output ce_n, adv_n, we_n, config_register_enable, addr_hi, adq_h, adq_h_oe,
		input  adq_d, adq_d_oe, wait_out, wait_oe
	);
endinterface
`default_nettype wire

// ===== src/psram_config_device.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - wait timing 0: data follows wait edge
// - wait timing 1: wait leads data by one
// - polarity 1 makes asserted wait high
// - latency field sets clocks to first data
// - latency field resets to code three
// - variable codes 2-4, collision doubles
// - controller watches wait in variable mode
// - fixed latency already covers refresh collision
// - fixed codes 2-6 and 0 as 8
// - controller picks latency for its clock
// - mode bit, resets to asynchronous
// - refresh register resets to 0010h
// - refresh register by select 00 or key 0000h
// - controller writes reserved refresh bits zero
// - refresh register reads back as written
// - partial refresh window from select code
// - power-down bit 0 plus chip high enters
// - long chip-low wakes, sets bit back
// - initialization wait after wake
// - registers kept in power-down, except bus bit 4 and the power-down bit
// - identification by select 01 or key 0002h
// - identification field layout
module psram_config_device #(
	parameter int         INIT_CYCLES      = psram_cfg_pkg::INIT_CYCLES,
	parameter int         REFRESH_INTERVAL = 64,
	parameter logic [3:0] VERSION          = 4'h0,
	parameter logic [2:0] GENERATION       = 3'h0,
	parameter logic [4:0] VENDOR           = 5'h15
) (
	input  wire logic         clock,
	input  wire logic         reset,
	psram_link_if.device_end  link,
	output logic              refresh_pulse,
	output logic [22:0]       refresh_first,
	output logic [22:0]       refresh_last,
	output logic              refresh_off,
	output logic              deep_power_down_active,
	output logic              init_busy,
	output logic              sync_mode
);
	localparam int CW = psram_cfg_pkg::CNT_W;

	typedef enum logic [5:0] {
		S_IDLE       = 6'h01,
		S_CFG        = 6'h02,
		S_HOLD       = 6'h04,
		S_BURST      = 6'h08,
		S_POWER_DOWN = 6'h10,
		S_INIT       = 6'h20
	} dev_state_t;

	dev_state_t     state_reg;
	dev_state_t     state_next;
	logic [15:0]    bus_configuration_reg;
	logic [15:0]    refresh_configuration_reg;
	logic [15:0]    dout_reg;
	logic           dvalid_reg;
	logic           we_reg;
	logic [1:0]     sel_reg;
	logic [3:0]     cnt_reg;
	logic [3:0]     target_reg;
	logic [1:0]     sw_step_reg;
	logic [1:0]     sw_sel_reg;
	logic [CW-1:0]  long_cnt_reg;
	logic [CW-1:0]  refresh_cnt_reg;
	logic           refresh_pulse_reg;

	// arbitrary vendor code value in VENDOR
	wire [15:0] device_identification = {psram_cfg_pkg::IDENT_ROW_256, VERSION,
		psram_cfg_pkg::IDENT_DENSITY, GENERATION, VENDOR};

	wire        start      = !link.ce_n && !link.adv_n;
	wire        sw_cfg     = sw_step_reg == 2'h3;
	wire        cfg_access = link.config_register_enable || sw_cfg;
	wire [1:0]  sel        = sw_cfg ? sw_sel_reg : link.addr_hi[psram_cfg_pkg::SEL_LSB +: 2];
	wire        max_addr   = (&link.addr_hi) && (&link.adq_h);
	wire        async_mode = bus_configuration_reg[psram_cfg_pkg::MODE_BIT];
	wire        fixed_mode = bus_configuration_reg[psram_cfg_pkg::FIXED_BIT];
	wire [2:0]  lat_code   = bus_configuration_reg[psram_cfg_pkg::LAT_LSB +: 3];
	wire        collision  = refresh_cnt_reg < CW'(psram_cfg_pkg::COLLISION_WINDOW);
	// fixed mode ignores collision: worst case is in the count
	wire [3:0]  latency    = psram_cfg_pkg::latency_clocks(lat_code, fixed_mode, collision);
	wire        hit        = state_reg == S_BURST && !dvalid_reg && cnt_reg == target_reg;
	wire        early      = hit || dvalid_reg;
	wire        sync_burst = state_reg == S_BURST && !async_mode;
	wire        wait_cfg   = bus_configuration_reg[psram_cfg_pkg::WAIT_CFG_BIT];
	wire        wait_pol   = bus_configuration_reg[psram_cfg_pkg::WAIT_POL_BIT];
	wire        wait_asserted = sync_burst && (wait_cfg ? !early : !dvalid_reg);
	wire        key_ok     = link.adq_h == psram_cfg_pkg::KEY_REFRESH || link.adq_h == psram_cfg_pkg::KEY_BUS
		|| link.adq_h == psram_cfg_pkg::KEY_IDENT;
	wire [1:0]  key_sel    = link.adq_h == psram_cfg_pkg::KEY_BUS ? psram_cfg_pkg::SEL_BUS
		: link.adq_h == psram_cfg_pkg::KEY_IDENT ? psram_cfg_pkg::SEL_IDENT : psram_cfg_pkg::SEL_REFRESH;
	wire [15:0] read_mux   = sel_reg == psram_cfg_pkg::SEL_REFRESH ? refresh_configuration_reg
		: sel_reg == psram_cfg_pkg::SEL_BUS ? bus_configuration_reg
		: sel_reg == psram_cfg_pkg::SEL_IDENT ? device_identification : 16'h0000;
	wire        pd_enable  = !refresh_configuration_reg[psram_cfg_pkg::DEEP_POWER_DOWN_BIT];
	wire        wake_done  = state_reg == S_POWER_DOWN && !link.ce_n
		&& long_cnt_reg == CW'(psram_cfg_pkg::WAKE_LOW_CYCLES - 1);
	wire        init_done  = state_reg == S_INIT && long_cnt_reg == CW'(INIT_CYCLES - 1);
	wire psram_cfg_pkg::refresh_window_t window =
		psram_cfg_pkg::refresh_window(refresh_configuration_reg[psram_cfg_pkg::REFRESH_SEL_LSB +: 3]);

	assign link.wait_out = wait_pol ? wait_asserted : !wait_asserted;
	assign link.wait_oe  = !link.ce_n;
	assign link.adq_d    = dout_reg;
	assign link.adq_d_oe = dvalid_reg && !we_reg;

	assign refresh_pulse          = refresh_pulse_reg;
	assign refresh_first          = window.first;
	assign refresh_last           = window.last;
	assign refresh_off            = window.none || state_reg == S_POWER_DOWN;
	assign deep_power_down_active = state_reg == S_POWER_DOWN;
	assign init_busy              = state_reg == S_INIT;
	assign sync_mode              = !async_mode;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (pd_enable && link.ce_n) begin
					state_next = S_POWER_DOWN;
				end else if (start) begin
					state_next = cfg_access ? S_CFG : S_BURST;
				end
			end
			S_CFG: state_next = link.ce_n ? S_IDLE : S_HOLD;
			S_HOLD, S_BURST: begin
				if (link.ce_n) begin
					state_next = S_IDLE;
				end
			end
			S_POWER_DOWN: begin
				if (wake_done) begin
					state_next = S_INIT;
				end
			end
			S_INIT: begin
				if (init_done) begin
					state_next = S_IDLE;
				end
			end
			default: state_next = S_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_reg <= S_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// configuration registers survive power-down, except bus bit 4 and the refresh power-down bit
	always_ff @(posedge clock) begin
		if (reset) begin
			bus_configuration_reg     <= psram_cfg_pkg::BUS_CONFIG_RESET;
			refresh_configuration_reg <= psram_cfg_pkg::REFRESH_CONFIG_RESET;
		end else if (state_reg == S_CFG && we_reg) begin
			if (sel_reg == psram_cfg_pkg::SEL_REFRESH) begin
				refresh_configuration_reg <= link.adq_h;
			end
			if (sel_reg == psram_cfg_pkg::SEL_BUS) begin
				bus_configuration_reg <= link.adq_h;
			end
		end else if (wake_done) begin
			refresh_configuration_reg[psram_cfg_pkg::DEEP_POWER_DOWN_BIT] <= 1'h1;
			bus_configuration_reg[psram_cfg_pkg::BUS_LOST_BIT] <=
				psram_cfg_pkg::BUS_CONFIG_RESET[psram_cfg_pkg::BUS_LOST_BIT];
		end
	end

	// access capture and burst data path
	always_ff @(posedge clock) begin
		if (reset) begin
			dout_reg   <= 16'h0000;
			dvalid_reg <= 1'h0;
			we_reg     <= 1'h0;
			sel_reg    <= 2'h0;
			cnt_reg    <= 4'h0;
			target_reg <= 4'h0;
		end else if (state_reg == S_IDLE && state_next != S_POWER_DOWN && start) begin
			we_reg     <= !link.we_n;
			sel_reg    <= sel;
			dout_reg   <= link.adq_h;
			cnt_reg    <= 4'h1;
			target_reg <= latency;
			dvalid_reg <= async_mode && !cfg_access;
		end else if (state_next == S_IDLE || state_next == S_POWER_DOWN) begin
			dvalid_reg <= 1'h0;
		end else if (state_reg == S_CFG && !we_reg) begin
			dout_reg   <= read_mux;
			dvalid_reg <= 1'h1;
		end else if (state_reg == S_BURST) begin
			if (dvalid_reg) begin
				dout_reg <= dout_reg + 16'h0001;
			end else if (hit) begin
				dvalid_reg <= 1'h1;
			end else begin
				cnt_reg <= cnt_reg + 4'h1;
			end
		end
	end

	// key sequence: two top-address reads, then key write
	always_ff @(posedge clock) begin
		if (reset) begin
			sw_step_reg <= 2'h0;
			sw_sel_reg  <= 2'h0;
		end else if (state_reg == S_IDLE && start) begin
			if (cfg_access || !max_addr) begin
				sw_step_reg <= 2'h0;
			end else if (link.we_n && sw_step_reg < 2'h2) begin
				sw_step_reg <= sw_step_reg + 2'h1;
			end else if (!(!link.we_n && sw_step_reg == 2'h2)) begin
				sw_step_reg <= 2'h0;
			end
		end else if (state_reg == S_BURST && dvalid_reg && we_reg && sw_step_reg == 2'h2) begin
			sw_step_reg <= key_ok ? 2'h3 : 2'h0;
			sw_sel_reg  <= key_sel;
		end
	end

	// wake and initialisation timing
	always_ff @(posedge clock) begin
		if (reset || state_next != state_reg) begin
			long_cnt_reg <= '0;
		end else if (state_reg == S_POWER_DOWN) begin
			long_cnt_reg <= link.ce_n ? '0 : long_cnt_reg + CW'(1);
		end else if (state_reg == S_INIT) begin
			long_cnt_reg <= long_cnt_reg + CW'(1);
		end
	end

	// internal refresh timer, stopped while powered down
	always_ff @(posedge clock) begin
		if (reset || state_reg == S_POWER_DOWN) begin
			refresh_cnt_reg   <= CW'(REFRESH_INTERVAL - 1);
			refresh_pulse_reg <= 1'h0;
		end else begin
			refresh_cnt_reg   <= refresh_cnt_reg == '0 ? CW'(REFRESH_INTERVAL - 1) : refresh_cnt_reg - CW'(1);
			refresh_pulse_reg <= refresh_cnt_reg == '0 && !window.none;
		end
	end
endmodule
`default_nettype wire

// ===== src/psram_config_host.sv
`timescale 1ns/1ps
`default_nettype none
module psram_config_host #(
	parameter int INIT_CYCLES = psram_cfg_pkg::INIT_CYCLES
) (
	input  wire logic         clock,
	input  wire logic         reset,
	psram_link_if.host_end    link,
	input  wire logic         cmd_valid,
	output logic              cmd_ready,
	input  wire psram_cfg_pkg::op_t cmd_op,
	input  wire logic [1:0]   cmd_sel,
	input  wire logic [22:0]  cmd_addr,
	input  wire logic [15:0]  cmd_wdata,
	input  wire logic [7:0]   cmd_len,
	output logic              rsp_valid,
	output logic [15:0]       rsp_data,
	output logic              init_busy
);
	localparam int CW = psram_cfg_pkg::CNT_W;

	typedef enum logic [7:0] {
		H_IDLE = 8'h01,
		H_ADDR = 8'h02,
		H_CFGW = 8'h04,
		H_CFGR = 8'h08,
		H_DATA = 8'h10,
		H_END  = 8'h20,
		H_WAKE = 8'h40,
		H_INIT = 8'h80
	} host_state_t;

	host_state_t        state_reg;
	psram_cfg_pkg::op_t op_reg;
	logic               ce_n_reg;
	logic               adv_n_reg;
	logic               we_n_reg;
	logic               cfg_reg;
	logic [6:0]         hi_reg;
	logic [15:0]        dout_reg;
	logic               oe_reg;
	logic [1:0]         sel_reg;
	logic [15:0]        wdata_reg;
	logic [7:0]         len_reg;
	logic [7:0]         idx_reg;
	logic [15:0]        shadow_reg;
	logic               wait_off_prev_reg;
	logic [CW-1:0]      cnt_reg;
	logic               rsp_valid_reg;
	logic [15:0]        rsp_data_reg;

	wire is_cfg   = cmd_op == psram_cfg_pkg::OP_CFG_WRITE || cmd_op == psram_cfg_pkg::OP_CFG_READ;
	wire is_write = cmd_op == psram_cfg_pkg::OP_CFG_WRITE || cmd_op == psram_cfg_pkg::OP_WRITE;
	wire is_read  = op_reg == psram_cfg_pkg::OP_READ;
	wire accept   = cmd_valid && state_reg == H_IDLE;
	wire wait_off = link.wait_out != shadow_reg[psram_cfg_pkg::WAIT_POL_BIT];
	// sync bursts watch wait; reads wait for device drive
	wire take = (!is_read || link.adq_d_oe) && (shadow_reg[psram_cfg_pkg::MODE_BIT]
		|| (shadow_reg[psram_cfg_pkg::WAIT_CFG_BIT] ? wait_off_prev_reg : wait_off));
	wire last = idx_reg == len_reg;
	wire [15:0] masked = cmd_sel == psram_cfg_pkg::SEL_REFRESH ?
		(cmd_wdata & psram_cfg_pkg::REFRESH_USED_MASK) : cmd_wdata;

	assign link.ce_n                   = ce_n_reg;
	assign link.adv_n                  = adv_n_reg;
	assign link.we_n                   = we_n_reg;
	assign link.config_register_enable = cfg_reg;
	assign link.addr_hi                = hi_reg;
	assign link.adq_h                  = dout_reg;
	assign link.adq_h_oe               = oe_reg;
	assign cmd_ready                   = state_reg == H_IDLE;
	assign rsp_valid                   = rsp_valid_reg;
	assign rsp_data                    = rsp_data_reg;
	assign init_busy                   = state_reg == H_WAKE || state_reg == H_INIT;

	always_ff @(posedge clock) begin
		if (reset) begin
			wait_off_prev_reg <= 1'h0;
			rsp_valid_reg     <= 1'h0;
			rsp_data_reg      <= 16'h0000;
		end else begin
			wait_off_prev_reg <= state_reg == H_DATA && wait_off;
			rsp_valid_reg     <= (state_reg == H_DATA && is_read && take)
				|| (state_reg == H_CFGR && link.adq_d_oe);
			rsp_data_reg      <= link.adq_d;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_reg  <= H_IDLE;
			op_reg     <= psram_cfg_pkg::OP_READ;
			ce_n_reg   <= 1'h1;
			adv_n_reg  <= 1'h1;
			we_n_reg   <= 1'h1;
			cfg_reg    <= 1'h0;
			hi_reg     <= 7'h00;
			dout_reg   <= 16'h0000;
			oe_reg     <= 1'h0;
			sel_reg    <= 2'h0;
			wdata_reg  <= 16'h0000;
			len_reg    <= 8'h00;
			idx_reg    <= 8'h00;
			shadow_reg <= psram_cfg_pkg::BUS_CONFIG_RESET;
			cnt_reg    <= '0;
		end else begin
			case (state_reg)
				H_IDLE: begin
					if (accept) begin
						op_reg    <= cmd_op;
						sel_reg   <= cmd_sel;
						wdata_reg <= masked;
						len_reg   <= cmd_len;
						idx_reg   <= 8'h00;
						cnt_reg   <= '0;
						ce_n_reg  <= 1'h0;
						if (cmd_op == psram_cfg_pkg::OP_WAKE) begin
							state_reg <= H_WAKE;
						end else begin
							state_reg <= H_ADDR;
							adv_n_reg <= 1'h0;
							we_n_reg  <= !is_write;
							cfg_reg   <= is_cfg;
							hi_reg    <= is_cfg ? 7'(cmd_sel) << psram_cfg_pkg::SEL_LSB : cmd_addr[22:16];
							dout_reg  <= is_cfg ? 16'h0000 : cmd_addr[15:0];
							oe_reg    <= 1'h1;
						end
					end
				end
				H_ADDR: begin
					adv_n_reg <= 1'h1;
					dout_reg  <= wdata_reg;
					oe_reg    <= op_reg == psram_cfg_pkg::OP_CFG_WRITE || op_reg == psram_cfg_pkg::OP_WRITE;
					state_reg <= op_reg == psram_cfg_pkg::OP_CFG_WRITE ? H_CFGW
						: op_reg == psram_cfg_pkg::OP_CFG_READ ? H_CFGR : H_DATA;
				end
				H_CFGW: begin
					if (sel_reg == psram_cfg_pkg::SEL_BUS) begin
						shadow_reg <= wdata_reg;
					end
					ce_n_reg  <= 1'h1;
					oe_reg    <= 1'h0;
					state_reg <= H_END;
				end
				H_CFGR: begin
					if (link.adq_d_oe) begin
						if (sel_reg == psram_cfg_pkg::SEL_BUS) begin
							shadow_reg <= link.adq_d;
						end
						ce_n_reg  <= 1'h1;
						state_reg <= H_END;
					end
				end
				H_DATA: begin
					if (take) begin
						idx_reg  <= idx_reg + 8'h01;
						dout_reg <= dout_reg + 16'h0001;
						if (last) begin
							ce_n_reg  <= 1'h1;
							oe_reg    <= 1'h0;
							state_reg <= H_END;
						end
					end
				end
				H_WAKE: begin
					cnt_reg <= cnt_reg + CW'(1);
					if (cnt_reg == CW'(psram_cfg_pkg::WAKE_LOW_CYCLES - 1)) begin
						ce_n_reg  <= 1'h1;
						cnt_reg   <= '0;
						state_reg <= H_INIT;
						shadow_reg[psram_cfg_pkg::BUS_LOST_BIT] <=
							psram_cfg_pkg::BUS_CONFIG_RESET[psram_cfg_pkg::BUS_LOST_BIT];
					end
				end
				H_INIT: begin
					cnt_reg <= cnt_reg + CW'(1);
					if (cnt_reg == CW'(INIT_CYCLES - 1)) begin
						state_reg <= H_IDLE;
					end
				end
				H_END: state_reg <= H_IDLE;
				default: state_reg <= H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== testbench/psram_config_properties.sv
`timescale 1ns/1ps
`default_nettype none
module psram_config_properties (
	input wire logic        clock,
	input wire logic        reset,
	input wire logic        ce_n,
	input wire logic        adv_n,
	input wire logic        we_n,
	input wire logic        config_register_enable,
	input wire logic [6:0]  addr_hi,
	input wire logic [15:0] adq_h,
	input wire logic        adq_h_oe,
	input wire logic [15:0] adq_d,
	input wire logic        adq_d_oe,
	input wire logic        wait_out,
	input wire logic        wait_oe
);
	logic [15:0] bus_reg;
	logic        wr_pend;
	logic        acc_cfg;
	logic        acc_sync;
	logic [4:0]  lat_cnt;
	wire logic       start_w = !ce_n && !adv_n;
	wire logic       pol_w   = bus_reg[psram_cfg_pkg::WAIT_POL_BIT];
	wire logic [2:0] code_w  = bus_reg[13:11];
	wire logic [4:0] fix_w   = (code_w >= 3'h2 && code_w <= 3'h6) ? {2'h0, code_w} : 5'h08;
	wire logic [4:0] var_w   = (code_w >= 3'h2 && code_w <= 3'h4) ? {2'h0, code_w} : 5'h08;
	// bus register shadow from config writes
	always_ff @(posedge clock) begin
		if (reset) begin
			bus_reg  <= psram_cfg_pkg::BUS_CONFIG_RESET;
			wr_pend  <= 1'h0;
			acc_cfg  <= 1'h0;
			acc_sync <= 1'h0;
			lat_cnt  <= 5'h1F;
		end else begin
			wr_pend <= start_w && config_register_enable && !we_n && addr_hi[3:2] == psram_cfg_pkg::SEL_BUS;
			if (wr_pend) begin
				bus_reg <= adq_h;
			end
			if (start_w) begin
				acc_cfg  <= config_register_enable;
				acc_sync <= !bus_reg[psram_cfg_pkg::MODE_BIT] && we_n && !config_register_enable;
				lat_cnt  <= 5'h01;
			end else if (lat_cnt != 5'h1F) begin
				lat_cnt <= lat_cnt + 5'h01;
			end
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	sequence sync_start_s;
		start_w && we_n && !config_register_enable && !bus_reg[psram_cfg_pkg::MODE_BIT];
	endsequence
	sequence data_start_s;
		$rose(adq_d_oe) && acc_sync;
	endsequence
	idle_after_reset_a: assert property ($fell(reset) |-> ce_n && !adq_d_oe && !adq_h_oe)
		else $error("link busy after reset");
	wait_drive_a: assert property (wait_oe == !ce_n)
		else $error("wait drive wrong");
	bus_single_a: assert property (!(adq_h_oe && adq_d_oe))
		else $error("bus contention");
	read_drive_a: assert property (adq_d_oe |-> we_n)
		else $error("device drove write");
	wait_level_a: assert property (sync_start_s |=> wait_out == pol_w)
		else $error("wait not asserted");
	wait_lead_a: assert property (data_start_s and bus_reg[8] |-> $past(wait_out) != pol_w && $past(wait_out, 2) == pol_w)
		else $error("wait lead wrong");
	wait_follow_a: assert property (data_start_s and !bus_reg[8] |-> wait_out != pol_w && $past(wait_out) == pol_w)
		else $error("wait follow wrong");
	fixed_lat_a: assert property (data_start_s and bus_reg[14] |-> lat_cnt == fix_w + 5'h01)
		else $error("fixed latency wrong");
	var_lat_a: assert property (data_start_s and !bus_reg[14] |-> lat_cnt == var_w + 5'h01 || lat_cnt == {var_w[3:0], 1'h1})
		else $error("var latency wrong");
	cfg_read_lat_a: assert property ($rose(adq_d_oe) && acc_cfg |-> lat_cnt == 5'h02)
		else $error("config read latency wrong");
	burst_step_a: assert property (adq_d_oe && $past(adq_d_oe) && !ce_n && acc_sync |-> adq_d == $past(adq_d) + 16'h0001)
		else $error("burst step wrong");
endmodule
`default_nettype wire

// ===== testbench/psram_config_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module psram_config_registers_tb;
	logic               clock;
	logic               reset;
	logic               cmd_valid;
	logic               cmd_ready;
	psram_cfg_pkg::op_t cmd_op;
	logic [1:0]         cmd_sel;
	logic [22:0]        cmd_addr;
	logic [15:0]        cmd_wdata;
	logic [7:0]         cmd_len;
	logic               rsp_valid;
	logic [15:0]        rsp_data;
	logic               host_busy;
	logic               refresh_pulse;
	logic [22:0]        refresh_first;
	logic [22:0]        refresh_last;
	logic               refresh_off;
	logic               pd_active;
	logic               dev_busy;
	logic               sync_mode;
	logic [31:0]        seed;
	logic [31:0]        r;
	logic [15:0]        got[$];
	logic [15:0]        bus_val;
	logic [46:0]        win;
	logic [22:0]        addr;
	int                 err_total;
	int                 compares;
	int                 cycles;
	int                 pulses;
	int                 busy_cycles;
	psram_link_if link ();
	// identity fields are arbitrary values
	psram_config_device #(.INIT_CYCLES(20), .VERSION(4'hA), .GENERATION(3'h5), .VENDOR(5'h0B)) i_psram_config_device (
		.clock, .reset, .link(link), .refresh_pulse(refresh_pulse), .refresh_first(refresh_first),
		.refresh_last(refresh_last), .refresh_off(refresh_off), .deep_power_down_active(pd_active),
		.init_busy(dev_busy), .sync_mode(sync_mode));
	psram_config_host #(.INIT_CYCLES(20)) i_psram_config_host (
		.clock, .reset, .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_len(cmd_len), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .init_busy(host_busy));
	psram_config_properties i_psram_config_properties (
		.clock, .reset, .ce_n(link.ce_n), .adv_n(link.adv_n), .we_n(link.we_n),
		.config_register_enable(link.config_register_enable), .addr_hi(link.addr_hi), .adq_h(link.adq_h),
		.adq_h_oe(link.adq_h_oe), .adq_d(link.adq_d), .adq_d_oe(link.adq_d_oe), .wait_out(link.wait_out),
		.wait_oe(link.wait_oe));
	initial clock = 1'h0;
	always #2 clock = ~clock;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// {none, first, last} refreshed for a select code
	function automatic logic [46:0] window(input logic [2:0] c);
		logic [22:0] part;
		part = 23'h7FFFFF >> c[1:0];
		return {c == 3'h4, c[2] ? ~part : 23'h000000, c[2] ? 23'h7FFFFF : part};
	endfunction
	task automatic end_sim();
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] act);
		compares++;
		if (act !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, act);
		end
	endtask
	task automatic cmd(input psram_cfg_pkg::op_t op, input logic [1:0] sel, input logic [22:0] a,
			input logic [15:0] d, input logic [7:0] l, input int nrsp);
		int n;
		n = 0;
		got.delete();
		cmd_op <= op;
		cmd_sel <= sel;
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_len <= l;
		cmd_valid <= 1'h1;
		do @(posedge clock); while (cmd_ready !== 1'h1);
		cmd_valid <= 1'h0;
		do begin
			@(posedge clock);
			n++;
			if (rsp_valid === 1'h1) got.push_back(rsp_data);
		end while ((got.size() < nrsp || cmd_ready !== 1'h1 || host_busy === 1'h1) && n < 9000);
		if (n >= 9000) chk("command done", 1, 0);
	endtask
	always @(posedge clock) begin
		cycles++;
		if (refresh_pulse === 1'h1) pulses++;
		if (dev_busy === 1'h1) busy_cycles++;
		if (cycles == 40000) begin
			err_total++;
			end_sim();
		end
	end
	initial begin
		seed = 32'hAA7BC858;
		{err_total, compares, cycles, pulses, busy_cycles} = '0;
		reset = 1'h1;
		cmd_valid = 1'h0;
		cmd_op = psram_cfg_pkg::OP_CFG_READ;
		{cmd_sel, cmd_addr, cmd_wdata, cmd_len} = '0;
		repeat (3) @(posedge clock);
		reset <= 1'h0;
		@(posedge clock);
		cmd(psram_cfg_pkg::OP_CFG_READ, psram_cfg_pkg::SEL_BUS, 0, 0, 0, 1);
		chk("latency reset", 3'h3, got[0][13:11]);
		chk("mode reset", 2'h2, {got[0][15], sync_mode});
		chk("wait bits reset", 2'h3, {got[0][10], got[0][8]});
		cmd(psram_cfg_pkg::OP_CFG_READ, psram_cfg_pkg::SEL_REFRESH, 0, 0, 0, 1);
		chk("refresh reset", 16'h0010, got[0]);
		cmd(psram_cfg_pkg::OP_CFG_WRITE, psram_cfg_pkg::SEL_IDENT, 0, 16'h0000, 0, 0);
		cmd(psram_cfg_pkg::OP_CFG_READ, psram_cfg_pkg::SEL_IDENT, 0, 0, 0, 1);
		chk("ident", {1'h1, 4'hA, 3'h3, 3'h5, 5'h0B}, got[0]);
		for (int c = 0; c < 8; c++) begin
			cmd(psram_cfg_pkg::OP_CFG_WRITE, psram_cfg_pkg::SEL_REFRESH, 0, 16'h0010 | 16'(c), 0, 0);
			cmd(psram_cfg_pkg::OP_CFG_READ, psram_cfg_pkg::SEL_REFRESH, 0, 0, 0, 1);
			chk("refresh readback", 16'h0010 | 16'(c), got[0]);
			win = window(3'(c));
			chk("refresh off", win[46], refresh_off);
			if (!win[46]) chk("refresh window", win[45:0], {refresh_first, refresh_last});
		end
		for (int i = 0; i < 16; i++) begin
			r = (i == 0) ? 32'h00000031 : (i == 1) ? 32'h000000CE : rnd();
			bus_val = {1'h0, r[0], r[3:1], r[4], 1'h0, r[5], 3'h0, 1'h1, 4'hF};
			cmd(psram_cfg_pkg::OP_CFG_WRITE, psram_cfg_pkg::SEL_BUS, 0, bus_val, 0, 0);
			cmd(psram_cfg_pkg::OP_CFG_READ, psram_cfg_pkg::SEL_BUS, 0, 0, 0, 1);
			chk("bus readback", bus_val, got[0]);
			chk("sync mode", 1, sync_mode);
			addr = {r[30:24], r[31:16]};
			cmd(psram_cfg_pkg::OP_READ, 0, addr, 0, {6'h0, r[7:6]}, r[7:6] + 1);
			for (int k = 0; k <= r[7:6]; k++) chk("burst word", addr[15:0] + 16'(k), got[k]);
		end
		cmd(psram_cfg_pkg::OP_CFG_WRITE, psram_cfg_pkg::SEL_BUS, 0, psram_cfg_pkg::BUS_CONFIG_RESET, 0, 0);
		for (int j = 0; j < 2; j++) begin
			repeat (2) cmd(psram_cfg_pkg::OP_READ, 0, 23'h7FFFFF, 0, 0, 1);
			cmd(psram_cfg_pkg::OP_WRITE, 0, 23'h7FFFFF, j ? psram_cfg_pkg::KEY_IDENT : psram_cfg_pkg::KEY_REFRESH, 0, 0);
			cmd(psram_cfg_pkg::OP_READ, 0, 0, 0, 0, 1);
			chk("key access", j ? {1'h1, 4'hA, 3'h3, 3'h5, 5'h0B} : 16'h0017, got[0]);
		end
		cmd(psram_cfg_pkg::OP_CFG_WRITE, psram_cfg_pkg::SEL_BUS, 0, 16'h9D0F, 0, 0);
		cmd(psram_cfg_pkg::OP_CFG_WRITE, psram_cfg_pkg::SEL_REFRESH, 0, 16'h0005, 0, 0);
		repeat (4) @(posedge clock);
		chk("power down", 2'h3, {pd_active, refresh_off});
		r = pulses;
		repeat (200) @(posedge clock);
		chk("refresh in power down", r, pulses);
		busy_cycles = 0;
		cmd(psram_cfg_pkg::OP_WAKE, 0, 0, 0, 0, 0);
		chk("init length", 20, busy_cycles);
		chk("awake", 0, pd_active);
		cmd(psram_cfg_pkg::OP_CFG_READ, psram_cfg_pkg::SEL_REFRESH, 0, 0, 0, 1);
		chk("refresh after wake", 16'h0015, got[0]);
		cmd(psram_cfg_pkg::OP_CFG_READ, psram_cfg_pkg::SEL_BUS, 0, 0, 0, 1);
		chk("bus after wake", 16'h9D1F, got[0]);
		end_sim();
	end
endmodule
`default_nettype wire
